// >>> hdl/time_measure_consts.vh
// constants for the rear-port time and measurement codec
`ifndef TIME_MEASURE_CONSTS_VH
`define TIME_MEASURE_CONSTS_VH
// register byte addresses
`define REG_PORT_CFG      8'h00
`define REG_TIME_IN_LO    8'h04
`define REG_TIME_IN_HI    8'h08
`define REG_TIME_OUT0     8'h0c
`define REG_TIME_OUT1     8'h10
`define REG_TIME_OUT2     8'h14
`define REG_TIME_OUT3     8'h18
`define REG_TIME_STATUS   8'h1c
`define REG_PU_RAW        8'h20
`define REG_PU_WORD       8'h24
`define REG_MULT_HI       8'h28
`define REG_MULT_LO       8'h2c
`define REG_FLOAT_IN      8'h30
`define REG_FLOAT_HI      8'h34
`define REG_FLOAT_LO      8'h38
`define REG_REQ_ADDR      8'h3c
`define REG_IDLE_STATUS   8'h40
`define REG_RX_W01        8'h44
`define REG_RX_W23        8'h48
`define REG_RX_LO         8'h4c
`define REG_RX_HI         8'h50
// port configuration fields
`define CFG_ADDR_LSB      0
`define CFG_IDLE_LSB      8
`define CFG_BAUD_LSB      16
`define CFG_PAR_LSB       20
`define CFG_REV_BIT       22
`define CFG_RESET         32'h0003_0a01
// limits
`define ADDR_MIN          8'h01
`define ADDR_MAX          8'hf7
`define IDLE_MIN          5'h01
`define IDLE_MAX          5'h1e
`define BAUD_MAX          3'h5
`define PAR_MAX           2'h2
`define MS_MAX            16'hea5f
`define MIN_MAX           6'h3b
`define HOUR_MAX          5'h17
`define WDAY_MAX          3'h7
`define MONTH_MAX         4'hc
`define YEAR_MAX          7'h63
`define PU_POS_MAX        16'h7fff
`define PU_NEG_MIN        16'h8000
// idle timing
`define CLK_MHZ           250
`define MINUTE_SEC        60
`endif

// >>> hdl/modbus_time_measure_codec.v
// rear-port time stamp, scaled power and float codec with apb registers
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "time_measure_consts.vh"
module modbus_time_measure_codec #(
  parameter integer CYCLES_PER_SEC = `CLK_MHZ * 1000000
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        frame_seen,
  input  wire [7:0]  frame_addr,
  output wire        addr_match,
  output reg         port_default_q,
  output wire [7:0]  rear_port_slave_address,
  output wire [2:0]  rear_port_bit_rate,
  output wire [1:0]  rear_port_parity_select,
  output wire        time_order_reverse,
  input  wire [15:0] current_year
);

  reg  [31:0] cfg_q;
  reg  [31:0] tin_lo_q;
  reg  [31:0] tin_hi_q;
  reg  [31:0] pu_raw_q;
  reg  [31:0] float_q;
  reg  [31:0] rx_w01_q;
  reg  [31:0] rx_w23_q;
  reg  [15:0] mult_hi_hold_q;
  reg  [31:0] mult_q;
  reg  [15:0] mult_lo_hold_q;
  reg  [1:0]  g29_step_q;
  reg         g29_err_q;
  reg  [7:0]  req_addr_q;
  reg  [31:0] sec_cnt_q;
  reg  [5:0]  sec_q;
  reg  [4:0]  min_q;
  reg         fs_meta_q;
  reg         fs_sync_q;
  reg         fs_prev_q;
  reg  [7:0]  fa_meta_q;
  reg  [7:0]  fa_sync_q;

  wire        wr = psel & penable & pwrite;
  wire        rd = psel & penable & ~pwrite;

  assign pready = 1'b1;
  assign rear_port_slave_address = cfg_q[`CFG_ADDR_LSB +: 8];
  assign rear_port_bit_rate      = cfg_q[`CFG_BAUD_LSB +: 3];
  assign rear_port_parity_select = cfg_q[`CFG_PAR_LSB +: 2];
  assign time_order_reverse      = cfg_q[`CFG_REV_BIT];
  wire [4:0] idle_min = cfg_q[`CFG_IDLE_LSB +: 5];

  // time input fields, software writes them as unpacked values
  wire [15:0] ms_in    = tin_lo_q[15:0];
  wire [5:0]  min_in   = tin_lo_q[21:16];
  wire [4:0]  hour_in  = tin_lo_q[28:24];
  wire        valid_in = tin_lo_q[29];
  wire        dst_in   = tin_lo_q[30];
  wire [4:0]  day_in   = tin_hi_q[4:0];
  wire [2:0]  wday_in  = tin_hi_q[10:8];
  wire        wday_ok  = tin_hi_q[11];
  wire [3:0]  mon_in   = tin_hi_q[19:16];
  wire [6:0]  year_in  = tin_hi_q[30:24];

  wire [7:0] b1 = ms_in[7:0];
  wire [7:0] b2 = ms_in[15:8];
  wire [7:0] b3 = {valid_in, 1'b0, min_in};
  wire [7:0] b4 = {dst_in, 2'b00, hour_in};
  wire [2:0] wday_f = wday_ok ? wday_in : 3'h0;
  wire [7:0] b5 = {wday_f, day_in};
  wire [7:0] b6 = {4'h0, mon_in};
  wire [7:0] b7 = {1'b0, year_in};

  // byte stream order follows the selected time ordering
  wire [63:0] std_stream = {b1, b2, b3, b4, b5, b6, b7, 8'h00};
  wire [63:0] rev_stream = {b7, b6, b5, b4, b3, b2, b1, 8'h00};
  wire [63:0] stream = time_order_reverse ? rev_stream : std_stream;

  // range check and status of the written time fields, reserved bit of the minute byte dropped
  wire [7:0] r3 = std_stream[47:40];
  wire       range_ok = (ms_in <= `MS_MAX) && (min_in <= `MIN_MAX) &&
                        (hour_in <= `HOUR_MAX) && (mon_in <= `MONTH_MAX) &&
                        (mon_in != 4'h0) && (day_in != 5'h0) &&
                        (year_in <= `YEAR_MAX);

  // century nearest the current year, window of fifty either side
  function [15:0] expand_year;
    input [6:0]  yy;
    input [15:0] now;
    reg   [15:0] cent;
    reg   [15:0] cand;
    begin
      cent = now - (now % 16'd100);
      cand = cent + {9'h0, yy};
      if (cand > now + 16'd50)
        cand = cand - 16'd100;
      else if (cand + 16'd50 < now)
        cand = cand + 16'd100;
      expand_year = cand;
    end
  endfunction
  wire [15:0] full_year = expand_year(year_in, current_year);

  // received words as they came off the line; reserved bits are dropped
  wire [63:0] rx_raw     = {rx_w01_q, rx_w23_q};
  wire [55:0] rx_rev     = {rx_raw[15:8], rx_raw[23:16], rx_raw[31:24], rx_raw[39:32],
                            rx_raw[47:40], rx_raw[55:48], rx_raw[63:56]};
  wire [55:0] rx_b       = time_order_reverse ? rx_rev : rx_raw[63:8];
  wire [15:0] rx_ms      = {rx_b[47:40], rx_b[55:48]};
  wire        rx_valid   = rx_b[39];
  wire [5:0]  rx_min     = rx_b[37:32];
  wire        rx_dst     = rx_b[31];
  wire [4:0]  rx_hour    = rx_b[28:24];
  wire [2:0]  rx_wday    = rx_b[23:21];
  wire        rx_wday_ok = (rx_wday != 3'h0);
  wire [4:0]  rx_day     = rx_b[20:16];
  wire [3:0]  rx_mon     = rx_b[11:8];
  wire [6:0]  rx_year    = rx_b[6:0];

  // scaled integer power: saturate the raw per-unit value to 16 bits
  function [15:0] sat16;
    input [31:0] v;
    begin
      if (!v[31] && (v[30:15] != 16'h0))
        sat16 = `PU_POS_MAX;
      else if (v[31] && (v[30:15] != 16'hffff))
        sat16 = `PU_NEG_MIN;
      else
        sat16 = v[15:0];
    end
  endfunction

  function cfg_ok;
    input [31:0] v;
    begin
      cfg_ok = (v[`CFG_ADDR_LSB +: 8] >= `ADDR_MIN) &&
               (v[`CFG_ADDR_LSB +: 8] <= `ADDR_MAX) &&
               (v[`CFG_IDLE_LSB +: 5] >= `IDLE_MIN) &&
               (v[`CFG_IDLE_LSB +: 5] <= `IDLE_MAX) &&
               (v[`CFG_BAUD_LSB +: 3] <= `BAUD_MAX) &&
               (v[`CFG_PAR_LSB +: 2] <= `PAR_MAX);
    end
  endfunction

  wire unmapped = (paddr > `REG_RX_HI) || (paddr[1:0] != 2'b00);
  wire cfg_bad  = wr && (paddr == `REG_PORT_CFG) && !cfg_ok(pwdata);
  // the three-word group must be read in order, so a stray read errors
  wire g29_bad  = rd && (((paddr == `REG_MULT_HI) && (g29_step_q != 2'd1)) ||
                         ((paddr == `REG_MULT_LO) && (g29_step_q != 2'd2)));
  assign pslverr = psel & penable & (unmapped | cfg_bad | g29_bad);

  assign addr_match = fs_sync_q & ~fs_prev_q & (fa_sync_q == rear_port_slave_address);

  wire [31:0] idle_limit = {27'h0, idle_min};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q          <= `CFG_RESET;
      tin_lo_q       <= 32'h0;
      tin_hi_q       <= 32'h0;
      pu_raw_q       <= 32'h0;
      float_q        <= 32'h0;
      mult_hi_hold_q <= 16'h0;
      rx_w01_q       <= 32'h0;
      rx_w23_q       <= 32'h0;
      mult_q         <= 32'h0;
      mult_lo_hold_q <= 16'h0;
      g29_step_q     <= 2'd0;
      g29_err_q      <= 1'b0;
      req_addr_q     <= 8'h0;
    end else begin
      if (wr && !unmapped) begin
        case (paddr)
          `REG_PORT_CFG: if (cfg_ok(pwdata)) cfg_q <= pwdata & 32'h007f_1fff;
          `REG_TIME_IN_LO: tin_lo_q <= pwdata;
          `REG_TIME_IN_HI: tin_hi_q <= pwdata;
          `REG_PU_RAW: pu_raw_q <= pwdata;
          // multiplier from ratings: ct times vt over 110 V, already scaled
          `REG_MULT_HI: mult_q <= pwdata;
          `REG_FLOAT_IN: float_q <= pwdata;
          `REG_RX_W01: rx_w01_q <= pwdata;
          `REG_RX_W23: rx_w23_q <= pwdata;
          default: req_addr_q <= req_addr_q;
        endcase
      end
      // whole group snapshot on the first word, served in order
      if (rd && paddr == `REG_PU_WORD) begin
        mult_hi_hold_q <= mult_q[31:16];
        mult_lo_hold_q <= mult_q[15:0];
        g29_step_q     <= 2'd1;
      end else if (rd && paddr == `REG_MULT_HI && g29_step_q == 2'd1) begin
        g29_step_q <= 2'd2;
      end else if (rd && paddr == `REG_MULT_LO && g29_step_q == 2'd2) begin
        g29_step_q <= 2'd0;
      end
      if (g29_bad)
        g29_err_q <= 1'b1;
      else if (rd && paddr == `REG_PU_WORD)
        g29_err_q <= 1'b0;
      if (addr_match)
        req_addr_q <= fa_sync_q;
    end
  end

  // frame inputs come from the serial receiver in another domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fa_meta_q <= 8'h0;
      fa_sync_q <= 8'h0;
    end else begin
      fs_meta_q <= frame_seen;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
      fa_meta_q <= frame_addr;
      fa_sync_q <= fa_meta_q;
    end
  end

  // idle timer counts minutes of silence, any frame restarts it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q      <= 32'h0;
      sec_q          <= 6'h0;
      min_q          <= 5'h0;
      port_default_q <= 1'b0;
    end else if (fs_sync_q & ~fs_prev_q) begin
      sec_cnt_q      <= 32'h0;
      sec_q          <= 6'h0;
      min_q          <= 5'h0;
      port_default_q <= 1'b0;
    end else if (!port_default_q) begin
      if (sec_cnt_q == CYCLES_PER_SEC - 1) begin
        sec_cnt_q <= 32'h0;
        if (sec_q == `MINUTE_SEC - 1) begin
          sec_q <= 6'h0;
          if ({27'h0, min_q + 5'h1} >= idle_limit)
            port_default_q <= 1'b1;
          else
            min_q <= min_q + 5'h1;
        end else begin
          sec_q <= sec_q + 6'h1;
        end
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
    end
  end

  // read word latched in the setup phase so the access phase shows a flop
  wire rd_setup = psel & ~penable & ~pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      case (paddr)
        `REG_PORT_CFG:    prdata <= cfg_q;
        `REG_TIME_IN_LO:  prdata <= tin_lo_q;
        `REG_TIME_IN_HI:  prdata <= tin_hi_q;
        `REG_TIME_OUT0:   prdata <= {16'h0, stream[63:48]};
        `REG_TIME_OUT1:   prdata <= {16'h0, stream[47:32]};
        `REG_TIME_OUT2:   prdata <= {16'h0, stream[31:16]};
        `REG_TIME_OUT3:   prdata <= {16'h0, stream[15:0]};
        `REG_TIME_STATUS: prdata <= {full_year, 7'h0, range_ok, r3[7], r3[5:0], 1'b0};
        `REG_PU_RAW:      prdata <= pu_raw_q;
        `REG_PU_WORD:     prdata <= {16'h0, sat16(pu_raw_q)};
        `REG_MULT_HI:     prdata <= {16'h0, mult_hi_hold_q};
        `REG_MULT_LO:     prdata <= {16'h0, mult_lo_hold_q};
        `REG_FLOAT_IN:    prdata <= float_q;
        `REG_FLOAT_HI:    prdata <= {16'h0, float_q[31:16]};
        `REG_FLOAT_LO:    prdata <= {16'h0, float_q[15:0]};
        `REG_REQ_ADDR:    prdata <= {24'h0, req_addr_q};
        `REG_IDLE_STATUS: prdata <= {24'h0, g29_err_q, port_default_q, 1'b0, min_q};
        `REG_RX_LO:       prdata <= {1'b0, rx_dst, rx_valid, rx_hour, 2'b00, rx_min, rx_ms};
        `REG_RX_HI:       prdata <= {1'b0, rx_year, 4'h0, rx_mon, 4'h0,
                                     rx_wday_ok, rx_wday, 3'h0, rx_day};
        default:          prdata <= 32'h0;
      endcase
    end else begin
      prdata <= 32'h0;
    end
  end

endmodule // modbus_time_measure_codec

// >>> testbench/time_measure_checker.sv
// port assertions for the time and measurement codec
`timescale 1ns/100ps
module time_measure_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pslverr,
  input logic        frame_seen,
  input logic [7:0]  frame_addr,
  input logic        addr_match,
  input logic        port_default_q,
  input logic [7:0]  rear_port_slave_address,
  input logic [2:0]  rear_port_bit_rate,
  input logic [1:0]  rear_port_parity_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire cfg_wr = acc && pwrite && paddr == 8'h00;
  wire hit = frame_addr == rear_port_slave_address;
  sequence s_rd(a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence s_cfg_ok;
    cfg_wr && pwdata[7:0] inside {[1:247]} && pwdata[12:8] inside {[1:30]}
      && pwdata[18:16] <= 5 && pwdata[21:20] <= 2;
  endsequence
  property p_cfg;
    s_cfg_ok |=> rear_port_slave_address == $past(pwdata[7:0])
      && rear_port_bit_rate == $past(pwdata[18:16])
      && rear_port_parity_select == $past(pwdata[21:20]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not taken");
  property p_rate_bad;
    cfg_wr && pwdata[18:16] > 5 |-> pslverr ##1 $stable(rear_port_bit_rate);
  endproperty
  a_rate_bad: assert property (p_rate_bad) else $error("bad rate taken");
  property p_par_bad;
    cfg_wr && pwdata[21:20] == 3 |-> pslverr ##1 $stable(rear_port_parity_select);
  endproperty
  a_par_bad: assert property (p_par_bad) else $error("bad parity taken");
  property p_addr_rng;
    rear_port_slave_address inside {[1:247]};
  endproperty
  a_addr_rng: assert property (p_addr_rng) else $error("address out of range");
  property p_match;
    addr_match |-> hit ##1 !addr_match;
  endproperty
  a_match: assert property (p_match) else $error("wrong match pulse");
  property p_nomatch;
    $rose(frame_seen) && !hit |=> !addr_match [*5];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign frame taken");
  property p_match_dly;
    $rose(frame_seen) && hit |-> ##[1:5] addr_match;
  endproperty
  a_match_dly: assert property (p_match_dly) else $error("match missing");
  property p_idle_clr;
    port_default_q && $rose(frame_seen) |-> ##[1:6] !port_default_q;
  endproperty
  a_idle_clr: assert property (p_idle_clr) else $error("default not left");
  property p_g29;
    s_rd(8'h24) ##[2:3] s_rd(8'h28) |-> !pslverr;
  endproperty
  a_g29: assert property (p_g29) else $error("whole group refused");
endmodule // time_measure_checker
bind modbus_time_measure_codec time_measure_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .frame_seen(frame_seen), .frame_addr(frame_addr),
  .addr_match(addr_match), .port_default_q(port_default_q),
  .rear_port_slave_address(rear_port_slave_address), .rear_port_bit_rate(rear_port_bit_rate),
  .rear_port_parity_select(rear_port_parity_select));

// >>> testbench/master_station_model.sv
// serial master stand-in announcing received frames
`timescale 1ns/100ps
module master_station_model (
  input  logic       pclk,
  output logic       frame_seen,
  output logic [7:0] frame_addr
);
  initial begin
    frame_seen = 1'b0;
    frame_addr = 8'h5a;
  end
  // address held well around the rise, then scrambled so nothing stale matches
  task automatic send(input logic [7:0] a);
    frame_addr <= a;
    repeat (2) @(posedge pclk);
    frame_seen <= 1'b1;
    repeat (6) @(posedge pclk);
    frame_seen <= 1'b0;
    repeat (2) @(posedge pclk);
    frame_addr <= ~a;
    @(posedge pclk);
  endtask
endmodule // master_station_model

// >>> testbench/modbus_time_measure_codec_tb.sv
// self-checking bench for the time and measurement codec
`timescale 1ns/100ps
`include "time_measure_consts.vh"
module modbus_time_measure_codec_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er_s, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd_s, rdata, w4, w8, v, m;
  logic [15:0] cur_year = 16'h07d0;
  logic [63:0] tw, rz;
  wire  [31:0] prdata;
  wire         pready, pslverr, frame_seen, addr_match, port_default_q, rev;
  wire  [7:0]  frame_addr, slave_addr;
  wire  [2:0]  bit_rate;
  wire  [1:0]  parity;
  integer      num_errors = 0, num_checks = 0, seed = 82448, cyc = 0, n_match = 0, i, k;
  logic [31:0] bad [5] = '{32'h00030a00, 32'h00030af8, 32'h00031f01, 32'h00060a01, 32'h00330a01};
  logic [31:0] pu [6] = '{32'h74, 32'hffff7fff, 32'h7fff, 32'hffff8000, 32'h10000, 32'hff8c};
  modbus_time_measure_codec #(.CYCLES_PER_SEC(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_seen(frame_seen), .frame_addr(frame_addr), .addr_match(addr_match),
    .port_default_q(port_default_q), .rear_port_slave_address(slave_addr),
    .rear_port_bit_rate(bit_rate), .rear_port_parity_select(parity),
    .time_order_reverse(rev), .current_year(cur_year));
  master_station_model mst (.pclk(pclk), .frame_seen(frame_seen), .frame_addr(frame_addr));
  always #2 pclk = ~pclk;
  // read data captured with the pre-edge value, clear of any same-edge update
  always @(posedge pclk) begin
    if (psel && penable) begin
      rd_s <= prdata;
      er_s <= pslverr;
    end
    if (addr_match === 1'b1) n_match <= n_match + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    rdata = rd_s;
    err = er_s;
  endtask
  function automatic logic [55:0] pack(input logic [31:0] a, input logic [31:0] b);
    logic [2:0] wd;
    wd = b[11] ? b[10:8] : 3'h0;
    return {a[7:0], a[15:8], a[29], 1'b0, a[21:16], a[30], 2'h0, a[28:24], wd, b[4:0],
            4'h0, b[19:16], 1'b0, b[30:24]};
  endfunction
  function automatic logic [31:0] cent(input int y, input int cy);
    int c;
    c = cy - cy % 100 + y;
    if (c > cy + 50) c = c - 100;
    if (c < cy - 50) c = c + 100;
    return c;
  endfunction
  function automatic logic [15:0] sat(input logic [31:0] x);
    if ($signed(x) > 32767) return 16'h7fff;
    if ($signed(x) < -32768) return 16'h8000;
    return x[15:0];
  endfunction
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `REG_PORT_CFG, 0);
    chk("cfg reset", `CFG_RESET, rdata);
    for (i = 0; i < 6; i++) begin
      apb(1, `REG_PORT_CFG, {10'h0, 2'(i % 3), 1'b0, 3'(i), 3'h0, 5'h0a, 8'(i * 48 + 7)});
      chk("rate", i, bit_rate);
      chk("parity", i % 3, parity);
      chk("addr", i * 48 + 7, slave_addr);
    end
    for (i = 0; i < 5; i++) begin
      apb(1, `REG_PORT_CFG, bad[i]);
      chk("cfg refused", 1, err);
      chk("addr kept", 247, slave_addr);
    end
    apb(0, 8'h54, 0);
    chk("unmapped", 0, rdata);
    chk("unmapped err", 1, err);
    apb(1, `REG_PORT_CFG, 32'h0003012c);
    mst.send(8'h2c);
    mst.send(8'h2d);
    chk("matches", 1, n_match);
    apb(0, `REG_REQ_ADDR, 0);
    chk("last addr", 8'h2c, rdata);
    repeat (500) @(posedge pclk);
    chk("early idle", 0, port_default_q);
    for (i = 0; i < 300 && port_default_q !== 1'b1; i++) @(posedge pclk);
    chk("idle", 1, port_default_q);
    mst.send(8'h2c);
    chk("idle left", 0, port_default_q);
    for (k = 0; k < 6; k++) begin
      v = $random(seed);
      w4 = k ? {1'b0, v[1:0], 5'(v[6:2] % 24), 2'h0, 6'(v[12:7] % 60), 16'(v[31:16] % 60000)}
             : {3'h3, 5'h17, 2'h0, 6'h3b, 16'hea5f};
      w8 = k ? {1'b0, 7'(v[20:14] % 100), 4'h0, 4'(v[13:10] % 12 + 1), 4'h0, v[9],
                3'(v[8:6] % 7 + 1), 3'h0, 5'(v[4:0] % 31 + 1)}
             : {8'h63, 8'h0c, 8'h0f, 8'h1f};
      m = k ? v : 32'h0002e248;
      i = k ? 1950 + v[7:0] : 2050;
      if ((w8[30:24] + 150 - i % 100) % 100 == 0) i = i + 1;
      cur_year <= 16'(i);
      apb(1, `REG_PORT_CFG, 32'h00030a01 | (k[0] << 22));
      apb(1, `REG_TIME_IN_LO, w4);
      apb(1, `REG_TIME_IN_HI, w8);
      apb(0, `REG_TIME_STATUS, 0);
      chk("year", cent(w8[30:24], i), rdata[31:16]);
      chk("order", k[0], rev);
      tw = {pack(w4, w8), 8'h0};
      if (k[0]) tw[63:8] = {<<8{tw[63:8]}};
      for (i = 0; i < 4; i++) begin
        apb(0, 8'h0c + 8'(4 * i), 0);
        chk("time word", tw[63 - 16 * i -: 16], rdata);
      end
      // loop the words back with reserved bits set, which the decoder must drop
      rz = 64'h0000_4060_00f0_80ff;
      if (k[0]) rz[63:8] = {<<8{rz[63:8]}};
      apb(1, `REG_RX_W01, tw[63:32] | rz[63:32]);
      apb(1, `REG_RX_W23, tw[31:0] | rz[31:0]);
      apb(0, `REG_RX_LO, 0);
      chk("rx lo", w4, rdata);
      apb(0, `REG_RX_HI, 0);
      chk("rx hi", w8[11] ? w8 : w8 & 32'hffff_f0ff, rdata);
      apb(1, `REG_PU_RAW, pu[k]);
      apb(1, `REG_MULT_HI, m);
      apb(1, `REG_FLOAT_IN, w4);
      apb(0, `REG_PU_WORD, 0);
      chk("pu", sat(pu[k]), rdata[15:0]);
      apb(0, `REG_MULT_HI, 0);
      chk("mult hi", m[31:16], rdata);
      chk("mult hi err", 0, err);
      apb(0, `REG_MULT_LO, 0);
      chk("mult lo", m[15:0], rdata);
      chk("mult lo err", 0, err);
      apb(0, `REG_FLOAT_HI, 0);
      chk("float hi", w4[31:16], rdata);
      apb(0, `REG_FLOAT_LO, 0);
      chk("float lo", w4[15:0], rdata);
    end
    apb(0, `REG_MULT_LO, 0);
    chk("lone part", 1, err);
    stop_test;
  end
endmodule // modbus_time_measure_codec_tb
